/* File: rtl/fnsc_regs.svh */
`ifndef FNSC_REGS_SVH
`define FNSC_REGS_SVH
// Register offsets (byte addresses, one word each)
`define FNSC_OFF_CONFIG 8'h00
`define FNSC_OFF_STATUS 8'h04
`define FNSC_OFF_IRQ_STATUS 8'h08
`define FNSC_OFF_IRQ_MASK 8'h0C
`define FNSC_OFF_SETTINGS 8'h10
`define FNSC_OFF_SW_VERSION 8'h14
`define FNSC_OFF_GLOBAL_BASE 8'h20
// Switch bank fields
`define FNSC_SW_ADDR_LSB 0
`define FNSC_SW_ADDR_MSB 5
`define FNSC_SW_LOSS_EN 6
`define FNSC_SW_GLOBAL_EN 7
`define FNSC_NODE_ADDR_TOP 7'h40
// Settings fields
`define FNSC_SET_COND_BIT 0
`define FNSC_SET_REACT_LSB 4
`define FNSC_SET_REACT_MSB 6
`define FNSC_COND_RUN_ONLY 1'h1
`define FNSC_REACT_ALARM_ONLY 3'h4
// Interrupt status bits
`define FNSC_IRQ_LOSS 0
`define FNSC_IRQ_MISMATCH 1
`define FNSC_IRQ_ARMED 2
`define FNSC_IRQ_GLOBAL_WR 3
`define FNSC_IRQ_WIDTH 4
// Reset values
`define FNSC_SETTINGS_RST 8'h00
`define FNSC_MASK_RST 4'h0
// Edges after reset release before the switch synchroniser shows the pins
`define FNSC_SETTLE_EDGES 2'h2
// Arbitrary supported drive software version
`define FNSC_SW_VERSION_DEF 16'h0001
`define FNSC_GLOBAL_WORDS 8
`endif

/* File: rtl/fnsc_pkg.sv */
package fnsc_pkg;
   typedef struct packed
   {
      logic [6:0] nodeAddr;
      logic lossDetectEn;
      logic globalPublishEn;
   } fnsc_cfg_s;
   typedef struct packed
   {
      logic valid;
      logic [5:0] srcAddr;
      logic isGlobal;
      logic toThisNode;
   } fnsc_cmd_s;
   typedef struct packed
   {
      logic [2:0] idx;
      logic [15:0] data;
   } fnsc_word_s;
endpackage

/* File: rtl/fnsc_sync.sv */
`timescale 1ns/1ps
module fnsc_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] meta_next;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] sync_next;

   always_comb
   begin
      meta_next = asyncIn;
      sync_next = meta_reg;
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta_reg <= '0;
         sync_reg <= '0;
      end
      else
      begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   assign syncOut = sync_reg;
endmodule

/* File: rtl/fnsc_publisher.sv */
`timescale 1ns/1ps
`include "fnsc_regs.svh"
module fnsc_publisher
   import fnsc_pkg::*;
#(
   parameter int WORDS = `FNSC_GLOBAL_WORDS
)
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic tokenHeld,
   input wire logic wrEn,
   input wire logic [2:0] wrIdx,
   input wire logic [15:0] wrData,
   input wire logic [2:0] rdIdx,
   output logic [15:0] rdData,
   output logic pubValid,
   output fnsc_word_s pubWord,
   output logic pubDone
);
   typedef enum logic [1:0]
   {
      PUB_IDLE = 2'b00,
      PUB_SEND = 2'b01,
      PUB_WAIT = 2'b10
   } fnsc_pub_e;

   logic [15:0] store [WORDS];
   fnsc_pub_e state_reg;
   fnsc_pub_e state_next;
   logic [2:0] idx_reg;
   logic [2:0] idx_next;
   fnsc_word_s word_reg;
   fnsc_word_s word_next;
   logic done_next;
   logic done_reg;

   always_ff @(posedge clk)
   begin
      if (wrEn)
      begin
         store[wrIdx] <= wrData;
      end
   end

   assign rdData = store[rdIdx];

   // One whole sweep of every word per token hold, no request needed
   always_comb
   begin
      state_next = state_reg;
      idx_next = idx_reg;
      word_next = word_reg;
      done_next = 1'b0;
      unique case (state_reg)
         PUB_IDLE:
         begin
            if (enable && tokenHeld) // R11
            begin
               state_next = PUB_SEND;
               idx_next = 3'h0;
            end
         end
         PUB_SEND:
         begin
            word_next.idx = idx_reg;
            word_next.data = store[idx_reg];
            idx_next = idx_reg + 3'h1;
            if (idx_reg == 3'(WORDS - 1))
            begin
               state_next = PUB_WAIT;
               done_next = 1'b1;
            end
         end
         PUB_WAIT:
         begin
            // Waits for the token to leave so a hold is sent once only
            if (!tokenHeld)
            begin
               state_next = PUB_IDLE;
            end
         end
         default:
         begin
            state_next = PUB_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_reg <= PUB_IDLE;
         idx_reg <= 3'h0;
         word_reg <= '0;
         done_reg <= 1'b0;
         pubValid <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         idx_reg <= idx_next;
         word_reg <= word_next;
         done_reg <= done_next;
         pubValid <= (state_reg == PUB_SEND);
      end
   end

   assign pubWord = word_reg;
   assign pubDone = done_reg;
endmodule

/* File: rtl/fnsc_top.sv */
// How it works
// R1: Switch bank sampled once after power-up; later changes ignored.
// R2: Address field is switches one to six, switch one least significant.
// R3: Node address equals sixty-four minus six-bit switch value, range 1 to 64.
// R4: Integrator gives every node a distinct address; not checked here.
// R5: Switch seven on enables lost-master detection, off disables it.
// R6: Token rotation watched for master; master leaving rotation is link loss.
// R7: Enabled detection plus link loss raises network loss fault to drive.
// R8: Detection disarmed after power-up until first non-global command to us.
// R9: Alarm-only reaction with run-only detection suppresses the loss fault.
// R10: Switch eight on enables global data publication, off disables it.
// R11: Publication on: eight global words broadcast each token hold, unrequested.
// R12: Master reads broadcast data only on its own global read.
// R13: Global writes from the network accepted whatever switch eight says.
// R14: Software mismatch fault raised when drive software version is unsupported.
// R15: Loss detect condition 1 means only while running, 0 means always.
// R16: Loss reaction 4 means alarm only; contact open, drive keeps running.
// R17: Latched address and enables load only at power-up, then stay fixed.
// R18: Network loss fault held as a level until reset.
`timescale 1ns/1ps
`include "fnsc_regs.svh"
module fnsc_top
   import fnsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] configSwitchBank,
   input wire logic masterInRotation,
   input wire logic tokenHeld,
   input wire fnsc_cmd_s netCmd,
   input wire logic globalWrEn,
   input wire logic [2:0] globalWrIdx,
   input wire logic [15:0] globalWrData,
   input wire logic driveRunning,
   input wire logic [15:0] softwareVersionMonitor,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdData,
   output fnsc_cfg_s cfgOut,
   output logic networkLossFault,
   output logic faultContact,
   output logic softwareMismatchFault,
   output logic pubValid,
   output fnsc_word_s pubWord,
   output logic irq
);
   logic [7:0] swSync;
   logic rotSync;
   fnsc_cfg_s cfg_reg;
   fnsc_cfg_s cfg_next;
   logic latched_reg;
   logic latched_next;
   logic [1:0] settle_reg;
   logic [1:0] settle_next;
   logic armed_reg;
   logic armed_next;
   logic rotPrev_reg;
   logic rotPrev_next;
   logic loss_reg;
   logic loss_next;
   logic mismatch_reg;
   logic mismatch_next;
   logic [7:0] settings_reg;
   logic [7:0] settings_next;
   logic [`FNSC_IRQ_WIDTH-1:0] irqStat_reg;
   logic [`FNSC_IRQ_WIDTH-1:0] irqStat_next;
   logic [`FNSC_IRQ_WIDTH-1:0] irqMask_reg;
   logic [`FNSC_IRQ_WIDTH-1:0] irqMask_next;
   logic [31:0] rdData_reg;
   logic [31:0] rdData_next;
   logic [`FNSC_IRQ_WIDTH-1:0] events;
   logic linkLoss;
   logic suppress;
   logic lossSet;
   logic pubDone;
   logic [15:0] globalRd;
   logic [2:0] rdIdx;

   // Switches and rotation come from pins: two flops before any use
   fnsc_sync #(.WIDTH(8)) u_swSync
   (
      .clk(clk),
      .rst_b(rst_b),
      .asyncIn(configSwitchBank),
      .syncOut(swSync)
   );

   fnsc_sync #(.WIDTH(1)) u_rotSync
   (
      .clk(clk),
      .rst_b(rst_b),
      .asyncIn(masterInRotation),
      .syncOut(rotSync)
   );

   function automatic logic [6:0] decodeNode(input logic [5:0] sw);
      decodeNode = `FNSC_NODE_ADDR_TOP - {1'b0, sw}; // R3
   endfunction

   function automatic logic isGlobalWordAddr(input logic [7:0] a);
      isGlobalWordAddr = (a >= `FNSC_OFF_GLOBAL_BASE) &&
         (a < (`FNSC_OFF_GLOBAL_BASE + 8'(4 * `FNSC_GLOBAL_WORDS))) && (a[1:0] == 2'b00);
   endfunction

   assign rdIdx = regAddr[4:2];

   // Global writes land in the store regardless of switch eight
   fnsc_publisher #(.WORDS(`FNSC_GLOBAL_WORDS)) u_pub
   (
      .clk(clk),
      .rst_b(rst_b),
      .enable(cfg_reg.globalPublishEn), // R10
      .tokenHeld(tokenHeld),
      .wrEn(globalWrEn), // R13
      .wrIdx(globalWrIdx),
      .wrData(globalWrData),
      .rdIdx(rdIdx),
      .rdData(globalRd),
      .pubValid(pubValid),
      .pubWord(pubWord),
      .pubDone(pubDone)
   );

   // Synchroniser flops come out of reset as zeros; count two edges before trusting them
   always_comb
   begin
      settle_next = settle_reg;
      if (settle_reg != `FNSC_SETTLE_EDGES)
      begin
         settle_next = settle_reg + 2'h1;
      end
   end

   // Only the power-on reset restarts the count, so the latch is taken once
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         settle_reg <= 2'h0;
      end
      else
      begin
         settle_reg <= settle_next;
      end
   end

   // Latch configuration once; two synchroniser cycles of settling first
   always_comb
   begin
      cfg_next = cfg_reg;
      latched_next = latched_reg;
      // Latching earlier would read the synchroniser's reset zeros as node 64
      if (!latched_reg && (settle_reg == `FNSC_SETTLE_EDGES)) // R1 R17
      begin
         latched_next = 1'b1;
         cfg_next.nodeAddr = decodeNode(swSync[`FNSC_SW_ADDR_MSB:`FNSC_SW_ADDR_LSB]); // R2
         cfg_next.lossDetectEn = swSync[`FNSC_SW_LOSS_EN]; // R5
         cfg_next.globalPublishEn = swSync[`FNSC_SW_GLOBAL_EN]; // R10
      end
   end

   // Detection, arming and faults
   assign linkLoss = rotPrev_reg && !rotSync; // R6
   assign suppress = (settings_reg[`FNSC_SET_COND_BIT] == `FNSC_COND_RUN_ONLY) &&
      (settings_reg[`FNSC_SET_REACT_MSB:`FNSC_SET_REACT_LSB] == `FNSC_REACT_ALARM_ONLY); // R9
   // Run-only condition only counts a loss while the drive runs
   assign lossSet = cfg_reg.lossDetectEn && armed_reg && linkLoss && !suppress &&
      (!settings_reg[`FNSC_SET_COND_BIT] || driveRunning); // R7 R15

   always_comb
   begin
      rotPrev_next = rotSync;
      armed_next = armed_reg;
      if (latched_reg && netCmd.valid && netCmd.toThisNode && !netCmd.isGlobal)
      begin
         armed_next = 1'b1; // R8
      end
      loss_next = loss_reg || lossSet; // R18
      mismatch_next = latched_reg && (softwareVersionMonitor != `FNSC_SW_VERSION_DEF); // R14
   end

   assign events[`FNSC_IRQ_LOSS] = lossSet;
   assign events[`FNSC_IRQ_MISMATCH] = mismatch_next && !mismatch_reg;
   assign events[`FNSC_IRQ_ARMED] = armed_next && !armed_reg;
   assign events[`FNSC_IRQ_GLOBAL_WR] = globalWrEn;

   // Register port; set beats write-one-to-clear
   always_comb
   begin
      settings_next = settings_reg;
      irqMask_next = irqMask_reg;
      irqStat_next = irqStat_reg;
      rdData_next = 32'h0000_0000;
      if (regWr)
      begin
         unique case (regAddr)
            `FNSC_OFF_SETTINGS: settings_next = regWrData[7:0];
            `FNSC_OFF_IRQ_MASK: irqMask_next = regWrData[`FNSC_IRQ_WIDTH-1:0];
            `FNSC_OFF_IRQ_STATUS:
               irqStat_next = irqStat_reg & ~regWrData[`FNSC_IRQ_WIDTH-1:0];
            default: ;
         endcase
      end
      irqStat_next = irqStat_next | events;
      if (regRd)
      begin
         if (isGlobalWordAddr(regAddr))
         begin
            rdData_next = {16'h0000, globalRd};
         end
         else
         begin
            unique case (regAddr)
               `FNSC_OFF_CONFIG: rdData_next = {23'h000000, cfg_reg};
               `FNSC_OFF_STATUS:
                  rdData_next = {27'h0000000, pubDone, mismatch_reg, loss_reg,
                     armed_reg, latched_reg};
               `FNSC_OFF_IRQ_STATUS: rdData_next = {28'h0000000, irqStat_reg};
               `FNSC_OFF_IRQ_MASK: rdData_next = {28'h0000000, irqMask_reg};
               `FNSC_OFF_SETTINGS: rdData_next = {24'h000000, settings_reg};
               `FNSC_OFF_SW_VERSION: rdData_next = {16'h0000, softwareVersionMonitor};
               default: rdData_next = 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_reg <= '0;
         latched_reg <= 1'b0;
         armed_reg <= 1'b0;
         rotPrev_reg <= 1'b0;
         loss_reg <= 1'b0;
         mismatch_reg <= 1'b0;
         settings_reg <= `FNSC_SETTINGS_RST;
         irqStat_reg <= '0;
         irqMask_reg <= `FNSC_MASK_RST;
         rdData_reg <= 32'h0000_0000;
      end
      else
      begin
         cfg_reg <= cfg_next;
         latched_reg <= latched_next;
         armed_reg <= armed_next;
         rotPrev_reg <= rotPrev_next;
         loss_reg <= loss_next;
         mismatch_reg <= mismatch_next;
         settings_reg <= settings_next;
         irqStat_reg <= irqStat_next;
         irqMask_reg <= irqMask_next;
         rdData_reg <= rdData_next;
      end
   end

   assign regRdData = rdData_reg;
   assign cfgOut = cfg_reg;
   assign networkLossFault = loss_reg;
   // Alarm only keeps the contact open while the fault is still shown
   assign faultContact = loss_reg &&
      (settings_reg[`FNSC_SET_REACT_MSB:`FNSC_SET_REACT_LSB] != `FNSC_REACT_ALARM_ONLY); // R16
   assign softwareMismatchFault = mismatch_reg;
   assign irq = |(irqStat_reg & irqMask_reg);
endmodule

/* File: tb/fnsc_top_asserts.sv */
`timescale 1ns/1ps
`include "fnsc_regs.svh"
module fnsc_top_asserts
   import fnsc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] configSwitchBank,
   input wire logic masterInRotation,
   input wire logic [15:0] softwareVersionMonitor,
   input wire fnsc_cfg_s cfgOut,
   input wire logic networkLossFault,
   input wire logic faultContact,
   input wire logic softwareMismatchFault,
   input wire logic pubValid,
   input wire fnsc_word_s pubWord
);
   logic [3:0] age_reg;
   logic [3:0] age_next;
   // Saturates, so the latch check fires once per power-up
   always_comb
      age_next = (age_reg == 4'hF) ? age_reg : age_reg + 4'h1;
   always_ff @(posedge clk or negedge rst_b)
      if (!rst_b)
         age_reg <= 4'h0;
      else
         age_reg <= age_next;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence sBurst;
      pubValid [*8] ##1 !pubValid;
   endsequence
   AST_ADDR: assert property (age_reg == 4'h6 |->
      cfgOut.nodeAddr == `FNSC_NODE_ADDR_TOP - {1'b0, configSwitchBank[5:0]})
      else $error("node address wrong");
   AST_FLAGS: assert property (age_reg == 4'h6 |->
      cfgOut.lossDetectEn == configSwitchBank[6] && cfgOut.globalPublishEn == configSwitchBank[7])
      else $error("enable flags wrong");
   AST_HOLD: assert property (age_reg > 4'h5 |=> $stable(cfgOut))
      else $error("config moved");
   AST_STICKY: assert property (networkLossFault |=> networkLossFault)
      else $error("loss fault dropped");
   AST_LOSS_EN: assert property (networkLossFault |-> cfgOut.lossDetectEn)
      else $error("loss fault while disabled");
   AST_CAUSE: assert property ($rose(networkLossFault) |->
      !$past(masterInRotation, 2) || !$past(masterInRotation, 3))
      else $error("loss fault without master drop");
   AST_CONTACT: assert property (faultContact |-> networkLossFault)
      else $error("contact without fault");
   AST_BURST: assert property ($rose(pubValid) |-> pubWord.idx == 3'h0 ##0 sBurst)
      else $error("burst shape wrong");
   AST_ORDER: assert property (pubValid && $past(pubValid) |->
      pubWord.idx == $past(pubWord.idx) + 3'h1)
      else $error("word order wrong");
   AST_PUB_EN: assert property (pubValid |-> cfgOut.globalPublishEn)
      else $error("publish while disabled");
   AST_VERSION: assert property (age_reg > 4'h3 && $stable(softwareVersionMonitor) &&
      $past(softwareVersionMonitor, 2) == softwareVersionMonitor |=>
      softwareMismatchFault == ($past(softwareVersionMonitor) != `FNSC_SW_VERSION_DEF))
      else $error("mismatch flag wrong");
endmodule

/* File: tb/fnsc_net_model.sv */
`timescale 1ns/1ps
module fnsc_net_model
   import fnsc_pkg::*;
(
   input wire logic clk,
   output logic masterInRotation,
   output logic tokenHeld,
   output fnsc_cmd_s netCmd,
   output logic globalWrEn,
   output logic [2:0] globalWrIdx,
   output logic [15:0] globalWrData,
   input wire logic pubValid,
   input wire fnsc_word_s pubWord
);
   fnsc_word_s seen [8];
   initial
   begin
      masterInRotation = 1'b1;
      tokenHeld = 1'b0;
      netCmd = '0;
      globalWrEn = 1'b0;
      globalWrIdx = 3'h0;
      globalWrData = 16'hFFFF;
   end
   task automatic rotation(input logic up);
      @(posedge clk);
      masterInRotation <= up;
   endtask
   // Source is node 1, never the node under test
   task automatic command(input logic isGlobal, input logic toUs);
      @(posedge clk);
      netCmd <= '{1'b1, 6'h01, isGlobal, toUs};
      @(posedge clk);
      netCmd <= '0;
   endtask
   task automatic globalWrite(input logic [2:0] idx, input logic [15:0] data);
      @(posedge clk);
      globalWrEn <= 1'b1;
      globalWrIdx <= idx;
      globalWrData <= data;
      @(posedge clk);
      globalWrEn <= 1'b0;
      // Stale data scrambled so the block cannot lean on it
      globalWrData <= ~data;
   endtask
   // Broadcasts are only picked up inside this read
   task automatic globalRead(output int n);
      n = 0;
      @(posedge clk);
      tokenHeld <= 1'b1;
      repeat (14)
      begin
         @(posedge clk);
         if (pubValid === 1'b1)
         begin
            if (n < 8)
               seen[n] = pubWord;
            n++;
         end
      end
      tokenHeld <= 1'b0;
   endtask
endmodule

/* File: tb/fnsc_top_tb.sv */
`timescale 1ns/1ps
`include "fnsc_regs.svh"
module fnsc_top_tb
   import fnsc_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] configSwitchBank = 8'h00;
   logic driveRunning = 1'b0;
   logic [15:0] softwareVersionMonitor = `FNSC_SW_VERSION_DEF;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic masterInRotation, tokenHeld, globalWrEn, networkLossFault, faultContact;
   logic softwareMismatchFault, pubValid, irq;
   logic [2:0] globalWrIdx;
   logic [15:0] globalWrData;
   logic [31:0] regRdData;
   fnsc_cmd_s netCmd;
   fnsc_cfg_s cfgOut;
   fnsc_word_s pubWord;
   int miscompares = 0;
   int n_tests = 0;
   always #25 clk = ~clk;
   fnsc_top dut (.clk(clk), .rst_b(rst_b), .configSwitchBank(configSwitchBank),
      .masterInRotation(masterInRotation), .tokenHeld(tokenHeld), .netCmd(netCmd),
      .globalWrEn(globalWrEn), .globalWrIdx(globalWrIdx), .globalWrData(globalWrData),
      .driveRunning(driveRunning), .softwareVersionMonitor(softwareVersionMonitor),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .cfgOut(cfgOut), .networkLossFault(networkLossFault),
      .faultContact(faultContact), .softwareMismatchFault(softwareMismatchFault),
      .pubValid(pubValid), .pubWord(pubWord), .irq(irq));
   fnsc_net_model net (.clk(clk), .masterInRotation(masterInRotation),
      .tokenHeld(tokenHeld), .netCmd(netCmd), .globalWrEn(globalWrEn),
      .globalWrIdx(globalWrIdx), .globalWrData(globalWrData), .pubValid(pubValid),
      .pubWord(pubWord));
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic powerUp(input logic [7:0] sw);
      @(posedge clk);
      rst_b <= 1'b0;
      configSwitchBank <= sw;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      repeat (8) @(posedge clk);
   endtask
   task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask
   task automatic regRead(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask
   task automatic testConfig;
      logic [7:0] sw [4] = '{8'h3F, 8'h00, 8'h40, 8'hC3};
      foreach (sw[i])
      begin
         powerUp(sw[i]);
         chk(cfgOut, {7'h40 - {1'b0, sw[i][5:0]}, sw[i][6], sw[i][7]});
      end
      @(posedge clk);
      configSwitchBank <= 8'h3C;
      repeat (6) @(posedge clk);
      chk(cfgOut, {7'h3D, 1'b1, 1'b1});
   endtask
   // Each case: switches, settings, running, expected fault, expected contact
   task automatic testLoss;
      logic [18:0] cs [6] = '{{8'h40, 8'h00, 3'h3}, {8'h40, 8'h01, 3'h0},
         {8'h40, 8'h01, 3'h7}, {8'h40, 8'h40, 3'h2}, {8'h40, 8'h41, 3'h4},
         {8'h00, 8'h00, 3'h0}};
      foreach (cs[i])
      begin
         powerUp(cs[i][18:11]);
         regWrite(`FNSC_OFF_SETTINGS, {24'h0, cs[i][10:3]});
         driveRunning <= cs[i][2];
         net.command(1'b1, 1'b1);
         net.command(1'b0, 1'b0);
         net.rotation(1'b0);
         repeat (8) @(posedge clk);
         chk(networkLossFault, 1'b0);
         net.rotation(1'b1);
         repeat (8) @(posedge clk);
         net.command(1'b0, 1'b1);
         net.rotation(1'b0);
         repeat (8) @(posedge clk);
         chk(networkLossFault, cs[i][1]);
         chk(faultContact, cs[i][0]);
         net.rotation(1'b1);
         repeat (8) @(posedge clk);
         chk(networkLossFault, cs[i][1]);
      end
   endtask
   task automatic testPublish;
      int n;
      logic [31:0] d;
      powerUp(8'h80);
      for (int i = 0; i < 8; i++)
         net.globalWrite(i[2:0], 16'hA500 + i[15:0]);
      net.globalRead(n);
      chk(n, 8);
      foreach (net.seen[i])
         chk(net.seen[i], {i[2:0], 16'hA500 + i[15:0]});
      net.globalRead(n);
      chk(n, 8);
      powerUp(8'h00);
      net.globalWrite(3'h5, 16'h5A3C);
      regRead(`FNSC_OFF_GLOBAL_BASE + 8'h14, d);
      chk(d[15:0], 16'h5A3C);
      net.globalRead(n);
      chk(n, 0);
   endtask
   task automatic testIrq;
      logic [31:0] d;
      logic [15:0] ver [3] = '{16'h0000, 16'h8001, `FNSC_SW_VERSION_DEF};
      powerUp(8'h00);
      foreach (ver[i])
      begin
         softwareVersionMonitor <= ver[i];
         repeat (6) @(posedge clk);
         chk(softwareMismatchFault, ver[i] != `FNSC_SW_VERSION_DEF);
      end
      regRead(`FNSC_OFF_IRQ_STATUS, d);
      chk(d & 32'h2, 32'h2);
      regWrite(`FNSC_OFF_IRQ_STATUS, 32'hF);
      net.globalWrite(3'h1, 16'h1234);
      regRead(`FNSC_OFF_IRQ_STATUS, d);
      chk(d & 32'h8, 32'h8);
      chk(irq, 1'b0);
      regWrite(`FNSC_OFF_IRQ_MASK, 32'h8);
      @(posedge clk);
      #1 chk(irq, 1'b1);
      regWrite(`FNSC_OFF_IRQ_STATUS, 32'h8);
      @(posedge clk);
      #1 chk(irq, 1'b0);
      regRead(8'hF0, d);
      chk(d, 32'h0);
   endtask
   initial
   begin
      testConfig;
      testLoss;
      testPublish;
      testIrq;
      finish_test;
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      miscompares++;
      finish_test;
   end
endmodule
bind fnsc_top fnsc_top_asserts chk (.clk(clk), .rst_b(rst_b),
   .configSwitchBank(configSwitchBank), .masterInRotation(masterInRotation),
   .softwareVersionMonitor(softwareVersionMonitor), .cfgOut(cfgOut),
   .networkLossFault(networkLossFault), .faultContact(faultContact),
   .softwareMismatchFault(softwareMismatchFault), .pubValid(pubValid), .pubWord(pubWord));
